/* src/acs_cfg.svh */
// constants for the adc conversion sequencer: addresses, fields, timing
// assumes a 125 MHz ref_clk and a single-master i2c bus
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH
// slave address, value is arbitrary
`define ACS_DEV_ADDR 7'h2A
// clock period and stretch bound per conversion (longest: round down)
`define ACS_CLK_NS 8
`define ACS_STRETCH_NS 8300
`define ACS_STRETCH_CYC ((`ACS_STRETCH_NS) / (`ACS_CLK_NS))
// written byte fields
`define ACS_KIND_BIT 7
`define ACS_VSRC_HI 6
`define ACS_VSRC_LO 4
`define ACS_CLKSEL_BIT 3
`define ACS_POL_BIT 2
`define ACS_CFGRST_BIT 1
`define ACS_SWEEP_HI 6
`define ACS_SWEEP_LO 5
`define ACS_PICK_BIT 1
`define ACS_ARR_BIT 0
// power-up values
`define ACS_VSRC_RST 3'h0
`define ACS_CLKSEL_RST 1'h0
`define ACS_POL_RST 1'h0
`define ACS_SWEEP_RST 2'h0
`define ACS_PICK_RST 1'h0
`define ACS_ARR_RST 1'h1
// sweep codes and counts
`define ACS_SWEEP_UP 2'h0
`define ACS_SWEEP_EIGHT 2'h1
`define ACS_EIGHT_RUNS 4'h8
// read framing
`define ACS_LEAD_BITS 4'hF
`define ACS_BYTE_BITS 4'h8
`define ACS_ADDR_LAST 4'h7
`define ACS_EXT_START_RISE 2'h2
`define ACS_MEM_ENTRIES 2'h2
`endif

/* src/acs_pkg.sv */
// types shared by the adc conversion sequencer files
// assumes acs_cfg.svh provides the numeric constants
package acs_pkg;
  // bus protocol phases
  typedef enum logic [2:0] {
    ACS_IDLE, ACS_ADDR, ACS_ADDR_ACK, ACS_WR_BYTE, ACS_WR_ACK,
    ACS_CONVERT, ACS_RD_BYTE, ACS_RD_ACK
  } acs_phase_t;
  // pin sampler state
  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_prev;
    logic sda_prev;
  } acs_pins_t;
  // sequencer state, outputs included
  typedef struct packed {
    acs_phase_t st;
    logic [3:0] bcnt;
    logic [1:0] rcnt;
    logic [7:0] shreg;
    logic rw;
    logic bsel;
    logic [2:0] vsrc;
    logic ext_clk;
    logic pol;
    logic [1:0] sweep;
    logic pick;
    logic arr;
    logic [1:0][11:0] mem;
    logic wptr;
    logic [1:0] rptr;
    logic [1:0] nstored;
    logic [3:0] nleft;
    logic cidx;
    logic [10:0] tmo;
    logic [11:0] word;
    logic sda_oe;
    logic scl_oe;
    logic conv_start;
    logic conv_step;
    logic track;
    logic pos_in;
    logic neg_in;
    logic neg_gnd;
    logic [4:0] refs;
  } acs_seq_t;
endpackage : acs_pkg

/* src/acs_pin_sampler.sv */
// two-stage synchroniser and edge finder for the scl and sda pins
// assumes pins are asynchronous to ref_clk
module acs_pin_sampler
  import acs_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // raw pins
  input wire logic scl_in,
  input wire logic sda_in,
  // sampled levels and events
  output logic sda_lvl,
  output logic scl_rise,
  output logic scl_fall,
  output logic bus_start,
  output logic bus_stop
);
  acs_pins_t q, d; // registered copy and next value

  // shift pins through the synchronisers
  always_comb begin
    d = q;
    d.scl_sync = {q.scl_sync[0], scl_in};
    d.sda_sync = {q.sda_sync[0], sda_in};
    d.scl_prev = q.scl_sync[1];
    d.sda_prev = q.sda_sync[1];
  end

  // register the state
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q <= '{scl_sync: 2'h3, sda_sync: 2'h3, scl_prev: 1'h1, sda_prev: 1'h1};
    end else begin
      q <= d;
    end
  end

  // only the second stage and its delayed copy are looked at
  assign sda_lvl = q.sda_sync[1];
  assign scl_rise = q.scl_sync[1] & ~q.scl_prev;
  assign scl_fall = ~q.scl_sync[1] & q.scl_prev;
  assign bus_start = q.scl_sync[1] & q.scl_prev & q.sda_prev & ~q.sda_sync[1];
  assign bus_stop = q.scl_sync[1] & q.scl_prev & ~q.sda_prev & q.sda_sync[1];
endmodule : acs_pin_sampler

/* src/acs_seq.sv */
// i2c slave that sequences adc conversions and returns their results
// assumes an analog core that starts on conv_start and answers conv_done;
// in external-clock mode it advances on conv_step pulses
`include "acs_cfg.svh"

module acs_seq
  import acs_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // i2c pins, open drain
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // analog core control
  output logic conv_start,
  output logic conv_step,
  output logic conv_track,
  output logic conv_pos_input,
  output logic conv_neg_input,
  output logic conv_neg_ground,
  output logic conv_polarity,
  input wire logic conv_done,
  input wire logic [11:0] conv_data,
  // reference control
  output logic ref_supply,
  output logic ref_pin_in,
  output logic ref_internal,
  output logic ref_pin_out,
  output logic ref_keep_on,
  // status
  output logic clock_mode_ext
);
  acs_seq_t q, d; // registered state and its next value
  logic sda_lvl, scl_rise, scl_fall, bus_start, bus_stop; // pin events
  logic [1:0] rnext; // read pointer after wrap
  logic [3:0] runs; // conversions to do this read

  // synchronised pins and bus conditions
  acs_pin_sampler u_pins (
    .ref_clk(ref_clk),
    .rst(rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_lvl(sda_lvl),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .bus_start(bus_start),
    .bus_stop(bus_stop)
  );

  // bit sent at index i (0 first) of a result byte
  function automatic logic tx_bit(input logic [11:0] w, input logic bs,
                                  input logic [2:0] i);
    logic [7:0] byt;
    byt = bs ? w[7:0] : {`ACS_LEAD_BITS, w[11:8]};
    return byt[3'h7 - i];
  endfunction : tx_bit

  // first input of a sweep
  function automatic logic first_ch(input logic [1:0] sw, input logic pk);
    return (sw == `ACS_SWEEP_UP) ? 1'h0 : pk;
  endfunction : first_ch

  // next input of a sweep: scan-up wraps back to input zero, other sweeps repeat the picked input
  function automatic logic next_ch(input logic [1:0] sw, input logic pk,
                                   input logic c);
    if (sw != `ACS_SWEEP_UP) begin
      return pk;
    end
    return (c == pk) ? 1'h0 : ~c;
  endfunction : next_ch

  // reference controls from the three choice bits
  function automatic logic [4:0] ref_map(input logic [2:0] s);
    logic [4:0] r;
    r[4] = (s[2:1] == 2'h0); // supply as reference
    r[3] = (s[2:1] == 2'h1); // pin is reference input
    r[2] = s[2]; // internal reference
    r[1] = (s[2:1] == 2'h3); // pin is reference output
    r[0] = s[2] & s[0]; // internal kept on
    return r;
  endfunction : ref_map

  // route the chosen input to the converter
  function automatic void route(input logic c, input logic arr,
                                output logic p, output logic n,
                                output logic g);
    p = c;
    n = ~c;
    g = arr;
  endfunction : route

  // conversions per read in internal mode
  always_comb begin
    unique case (q.sweep)
      `ACS_SWEEP_UP: runs = {3'h0, q.pick} + 4'h1;
      `ACS_SWEEP_EIGHT: runs = `ACS_EIGHT_RUNS;
      default: runs = 4'h1;
    endcase
  end

  // read pointer wrap over stored entries
  assign rnext = (q.rptr + 2'h1 >= q.nstored) ? 2'h0 : q.rptr + 2'h1;

  // protocol, conversion and readout
  always_comb begin
    d = q;
    d.conv_start = 1'h0;
    d.conv_step = 1'h0;
    d.refs = ref_map(q.vsrc);
    // scl drives the conversion in external mode
    if (q.ext_clk && scl_rise && q.st != ACS_IDLE) begin
      d.conv_step = 1'h1;
    end
    // external results arrive while bits stream out
    if (q.ext_clk && conv_done) begin
      d.word = conv_data;
    end
    unique case (q.st)
      ACS_IDLE: begin
        d.sda_oe = 1'h0;
        d.scl_oe = 1'h0;
      end
      ACS_ADDR: begin
        // collect address and direction
        if (scl_rise) begin
          d.shreg = {q.shreg[6:0], sda_lvl};
          d.bcnt = q.bcnt + 4'h1;
          if (q.bcnt == `ACS_ADDR_LAST) begin
            d.rw = sda_lvl;
            // internal mode tracks from the eighth rise
            if (!q.ext_clk && sda_lvl &&
                q.shreg[6:0] == `ACS_DEV_ADDR) begin
              d.track = 1'h1;
              d.cidx = first_ch(q.sweep, q.pick);
              route(d.cidx, q.arr, d.pos_in, d.neg_in, d.neg_gnd);
            end
          end
        end else if (scl_fall && q.bcnt == `ACS_BYTE_BITS) begin
          if (q.shreg[7:1] == `ACS_DEV_ADDR) begin
            d.sda_oe = 1'h1;
            d.st = ACS_ADDR_ACK;
          end else begin
            d.st = ACS_IDLE;
          end
        end
      end
      ACS_ADDR_ACK: begin
        // external mode tracks from the ninth rise
        if (scl_rise && q.ext_clk && q.rw) begin
          d.track = 1'h1;
          d.cidx = first_ch(q.sweep, q.pick);
          route(d.cidx, q.arr, d.pos_in, d.neg_in, d.neg_gnd);
        end else if (scl_fall) begin
          d.sda_oe = 1'h0;
          d.bcnt = 4'h0;
          d.rcnt = 2'h0;
          d.bsel = 1'h0;
          if (!q.rw) begin
            d.st = ACS_WR_BYTE;
          end else if (!q.ext_clk) begin
            // sample on the ninth fall and hold scl low
            d.track = 1'h0;
            d.conv_start = 1'h1;
            d.scl_oe = 1'h1;
            d.nleft = runs - 4'h1;
            d.tmo = 11'h0;
            d.wptr = 1'h0;
            d.nstored = 2'h0;
            d.st = ACS_CONVERT;
          end else begin
            d.st = ACS_RD_BYTE;
          end
        end
      end
      ACS_WR_BYTE: begin
        // collect one written byte
        if (scl_rise) begin
          d.shreg = {q.shreg[6:0], sda_lvl};
          d.bcnt = q.bcnt + 4'h1;
        end else if (scl_fall && q.bcnt == `ACS_BYTE_BITS) begin
          d.sda_oe = 1'h1;
          d.st = ACS_WR_ACK;
          if (q.shreg[`ACS_KIND_BIT]) begin
            // setup byte
            d.vsrc = q.shreg[`ACS_VSRC_HI:`ACS_VSRC_LO];
            d.ext_clk = q.shreg[`ACS_CLKSEL_BIT];
            d.pol = q.shreg[`ACS_POL_BIT];
            if (!q.shreg[`ACS_CFGRST_BIT]) begin
              d.sweep = `ACS_SWEEP_RST;
              d.pick = `ACS_PICK_RST;
              d.arr = `ACS_ARR_RST;
            end
          end else begin
            // configuration byte
            d.sweep = q.shreg[`ACS_SWEEP_HI:`ACS_SWEEP_LO];
            d.pick = q.shreg[`ACS_PICK_BIT];
            d.arr = q.shreg[`ACS_ARR_BIT];
          end
        end
      end
      ACS_WR_ACK: begin
        // release after the acknowledge bit
        if (scl_fall) begin
          d.sda_oe = 1'h0;
          d.bcnt = 4'h0;
          d.st = ACS_WR_BYTE;
        end
      end
      ACS_CONVERT: begin
        // store each result; give up after the stretch bound
        d.tmo = q.tmo + 11'h1;
        if (conv_done || q.tmo == 11'(`ACS_STRETCH_CYC)) begin
          d.mem[q.wptr] = conv_data;
          d.wptr = ~q.wptr;
          d.tmo = 11'h0;
          if (q.nstored != `ACS_MEM_ENTRIES) begin
            d.nstored = q.nstored + 2'h1;
          end
          if (q.nleft == 4'h0) begin
            // all stored: release scl, start from the oldest entry
            d.scl_oe = 1'h0;
            d.rptr = 2'h0;
            d.word = d.mem[0];
            d.sda_oe = 1'h0;
            d.st = ACS_RD_BYTE;
          end else begin
            d.nleft = q.nleft - 4'h1;
            d.cidx = next_ch(q.sweep, q.pick, q.cidx);
            route(d.cidx, q.arr, d.pos_in, d.neg_in, d.neg_gnd);
            d.conv_start = 1'h1;
          end
        end
      end
      ACS_RD_BYTE: begin
        // shift a result byte out, bit changes on scl fall
        if (scl_rise) begin
          d.bcnt = q.bcnt + 4'h1;
          if (q.rcnt != 2'h3) begin
            d.rcnt = q.rcnt + 2'h1;
          end
          // external sample two clocks after tracking starts
          if (q.ext_clk && !q.bsel &&
              q.rcnt + 2'h1 == `ACS_EXT_START_RISE) begin
            d.track = 1'h0;
            d.conv_start = 1'h1;
          end
        end else if (scl_fall) begin
          if (q.bcnt == `ACS_BYTE_BITS) begin
            d.sda_oe = 1'h0;
            d.st = ACS_RD_ACK;
          end else begin
            d.sda_oe = ~tx_bit(q.word, q.bsel, q.bcnt[2:0]);
          end
        end
      end
      ACS_RD_ACK: begin
        // master answer decides whether to go on
        if (scl_rise) begin
          if (sda_lvl) begin
            d.sda_oe = 1'h0;
            d.track = 1'h0;
            d.st = ACS_IDLE;
          end else if (q.bsel && q.ext_clk) begin
            // next streamed conversion tracks now
            d.cidx = next_ch(q.sweep, q.pick, q.cidx);
            route(d.cidx, q.arr, d.pos_in, d.neg_in, d.neg_gnd);
            d.track = 1'h1;
          end
        end else if (scl_fall) begin
          d.bsel = ~q.bsel;
          d.bcnt = 4'h0;
          d.rcnt = 2'h0;
          if (q.bsel && !q.ext_clk) begin
            d.rptr = rnext;
            d.word = q.mem[rnext[0]];
          end
          d.sda_oe = ~tx_bit(d.word, d.bsel, 3'h0);
          d.st = ACS_RD_BYTE;
        end
      end
      default: begin
        d.st = ACS_IDLE;
      end
    endcase
    // bus conditions override the phase
    if (bus_start) begin
      d.st = ACS_ADDR;
      d.bcnt = 4'h0;
      d.sda_oe = 1'h0;
      d.scl_oe = 1'h0;
      d.track = 1'h0;
    end else if (bus_stop) begin
      d.st = ACS_IDLE;
      d.sda_oe = 1'h0;
      d.scl_oe = 1'h0;
      d.track = 1'h0;
    end
  end

  // register the state, power-up configuration on reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q <= '0;
      q.st <= ACS_IDLE;
      q.vsrc <= `ACS_VSRC_RST;
      q.ext_clk <= `ACS_CLKSEL_RST;
      q.pol <= `ACS_POL_RST;
      q.sweep <= `ACS_SWEEP_RST;
      q.pick <= `ACS_PICK_RST;
      q.arr <= `ACS_ARR_RST;
      q.neg_gnd <= `ACS_ARR_RST;
      // reference controls follow the power-up choice from the first edge
      q.refs <= ref_map(`ACS_VSRC_RST);
    end else begin
      q <= d;
    end
  end

  // scl_out and sda_out tied low, other outputs straight from the state register
  assign scl_out = 1'h0;
  assign sda_out = 1'h0;
  assign scl_oe = q.scl_oe;
  assign sda_oe = q.sda_oe;
  assign conv_start = q.conv_start;
  assign conv_step = q.conv_step;
  assign conv_track = q.track;
  assign conv_pos_input = q.pos_in;
  assign conv_neg_input = q.neg_in;
  assign conv_neg_ground = q.neg_gnd;
  assign conv_polarity = q.pol;
  assign ref_supply = q.refs[4];
  assign ref_pin_in = q.refs[3];
  assign ref_internal = q.refs[2];
  assign ref_pin_out = q.refs[1];
  assign ref_keep_on = q.refs[0];
  assign clock_mode_ext = q.ext_clk;
endmodule : acs_seq

/* verif/acs_seq_assertions.sv */
// pin-level checker for acs_seq, bound to every instance
// assumes one ref_clk domain and a synchronous rst
`include "acs_cfg.svh"
module acs_seq_assertions (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // bus pins
  input wire logic scl_in,
  input wire logic scl_oe,
  input wire logic sda_oe,
  // converter control
  input wire logic conv_start,
  input wire logic conv_step,
  input wire logic conv_track,
  input wire logic conv_pos_input,
  input wire logic conv_neg_input,
  input wire logic conv_neg_ground,
  // reference and mode
  input wire logic ref_supply,
  input wire logic ref_pin_in,
  input wire logic ref_internal,
  input wire logic ref_pin_out,
  input wire logic ref_keep_on,
  input wire logic clock_mode_ext
);
  timeunit 1ns;
  timeprecision 100ps;
  // eight conversions at most, plus pin latency
  localparam int STRETCH_MAX = 8 * `ACS_STRETCH_CYC + 16;
  logic [13:0] stretch_cnt_reg; // length of the current stretch
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // counts cycles while scl is held low
  always_ff @(posedge ref_clk) begin
    if (rst || !scl_oe) stretch_cnt_reg <= 14'h0000;
    else stretch_cnt_reg <= stretch_cnt_reg + 14'h0001;
  end
  a_stretch_bound: assert property (stretch_cnt_reg <= STRETCH_MAX)
    else $error("scl stretch too long");
  a_int_stretch: assert property (
    conv_start && !clock_mode_ext |-> ##[0:1] scl_oe)
    else $error("internal conversion without stretch");
  a_ext_nostretch: assert property ($rose(scl_oe) |-> !clock_mode_ext)
    else $error("stretch in external mode");
  a_ext_step: assert property (conv_step |-> clock_mode_ext)
    else $error("step pulse in internal mode");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start pulse too long");
  a_ext_track: assert property (
    conv_start && clock_mode_ext |-> $past(conv_track))
    else $error("external start without tracking");
  a_sda_quiet: assert property ($changed(sda_oe) |-> !$past(scl_in))
    else $error("sda moved while scl high");
  a_ref_onehot: assert property (
    $onehot({ref_supply, ref_pin_in, ref_internal}))
    else $error("reference source not unique");
  a_ref_sub: assert property (
    (ref_pin_out || ref_keep_on) |-> ref_internal)
    else $error("reference option without internal source");
  a_diff_pair: assert property (
    !conv_neg_ground |-> conv_neg_input != conv_pos_input)
    else $error("differential pair on one input");
  // main scenarios reached
  c_stretch: cover property ($rose(scl_oe));
  c_step: cover property (conv_step);
  c_diff: cover property (!conv_neg_ground);
endmodule : acs_seq_assertions

bind acs_seq acs_seq_assertions u_acs_seq_assertions (.ref_clk, .rst,
  .scl_in, .scl_oe, .sda_oe, .conv_start, .conv_step, .conv_track,
  .conv_pos_input, .conv_neg_input, .conv_neg_ground, .ref_supply,
  .ref_pin_in, .ref_internal, .ref_pin_out, .ref_keep_on,
  .clock_mode_ext);

/* verif/acs_i2c_master.sv */
// i2c bus master model, pulls scl and sda low through enables
// assumes the bench resolves both wires with pull-ups
module acs_i2c_master (
  // resolved bus levels
  input wire logic scl,
  input wire logic sda,
  // pull-low enables and hang flag
  output logic scl_low,
  output logic sda_low,
  output logic stuck
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    stuck = 1'b0;
  end
  // release scl, wait out a stretch under a bound
  task automatic rise();
    int n;
    scl_low = 1'b0;
    n = 0;
    while (scl !== 1'b1 && n < 20000) begin
      #5;
      n++;
    end
    if (n == 20000) stuck = 1'b1;
  endtask : rise
  // 80 ns bit period, far under the slow-clock limits
  task automatic bit_x(input logic b, output logic r);
    #20 sda_low = ~b;
    #20 rise();
    #20 r = sda;
    #20 scl_low = 1'b1;
  endtask : bit_x
  // start: sda falls while scl high
  task automatic start();
    #40 sda_low = 1'b1;
    #40 scl_low = 1'b1;
  endtask : start
  // stop: sda rises while scl high
  task automatic stop();
    #20 sda_low = 1'b1;
    #20 rise();
    #40 sda_low = 1'b0;
    #40;
  endtask : stop
  // eight bits, msb first; ack choice is left to the caller
  task automatic byte_x(input logic [7:0] w, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) bit_x(w[i], r[i]);
  endtask : byte_x
endmodule : acs_i2c_master

/* verif/acs_seq_bench.sv */
// self-checking bench for acs_seq with an i2c master and a core model
// assumes acs_cfg.svh on the include path
`include "acs_cfg.svh"
`define ACS_CHK(a, b) begin checks++; if ((a) !== (b)) begin \
  fail_count++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); \
  end end
module acs_seq_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic scl, sda, m_scl, m_sda, stuck, scl_oe, sda_oe, ack;
  logic conv_start, conv_step, conv_track, pos, neg, gnd, pol, ext;
  logic conv_done = 1'b0;
  logic [11:0] conv_data = 12'h000;
  logic [11:0] kc = 12'h000; // conversions answered so far
  logic [11:0] kb; // kc when the read began
  logic [4:0] dly = 5'h00;
  wire [4:0] refs; // reference controls, one port per bit
  int fail_count = 0;
  int checks = 0;
  // setup byte per reference choice, expected reference controls
  logic [12:0] rows [8] = '{{8'h82, 5'h10}, {8'h92, 5'h10},
    {8'hA2, 5'h08}, {8'hB2, 5'h08}, {8'hC2, 5'h04}, {8'hD2, 5'h05},
    {8'hE2, 5'h06}, {8'hF2, 5'h07}};
  always #4 ref_clk = ~ref_clk;
  // open-drain wires with pull-ups
  assign scl = ~(m_scl | scl_oe);
  assign sda = ~(m_sda | sda_oe);
  acs_i2c_master u_acs_i2c_master (.scl(scl), .sda(sda),
    .scl_low(m_scl), .sda_low(m_sda), .stuck(stuck));
  acs_seq u_acs_seq (.ref_clk(ref_clk), .rst(rst), .scl_in(scl),
    .scl_out(), .scl_oe(scl_oe), .sda_in(sda), .sda_out(),
    .sda_oe(sda_oe), .conv_start(conv_start), .conv_step(conv_step),
    .conv_track(conv_track), .conv_pos_input(pos), .conv_neg_input(neg),
    .conv_neg_ground(gnd), .conv_polarity(pol), .conv_done(conv_done),
    .conv_data(conv_data), .ref_supply(refs[4]), .ref_pin_in(refs[3]),
    .ref_internal(refs[2]), .ref_pin_out(refs[1]),
    .ref_keep_on(refs[0]), .clock_mode_ext(ext));
  // core model: answers each start 10 cycles later with a tagged value
  always @(posedge ref_clk) begin
    conv_done <= 1'b0;
    if (dly != 5'h00) begin
      dly <= dly - 5'h01;
      if (dly == 5'h01) begin
        conv_done <= 1'b1;
        conv_data <= 12'h5A0 + kc;
        kc <= kc + 12'h001;
      end
    end else if (conv_start) dly <= 5'h0A;
  end
  task automatic final_report();
    if (fail_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  always @(posedge stuck) begin
    fail_count++;
    final_report();
  end
  initial begin
    #400000;
    fail_count++;
    final_report();
  end
  // start and address byte, ack returned
  task automatic waddr(input logic rw, input logic [6:0] a,
                       output logic k);
    logic [7:0] r;
    logic n;
    u_acs_i2c_master.start();
    u_acs_i2c_master.byte_x({a, rw}, r);
    u_acs_i2c_master.bit_x(1'b1, n);
    k = ~n;
  endtask : waddr
  // one written byte in its own transaction
  task automatic wr(input logic [7:0] b);
    logic [7:0] r;
    logic k;
    waddr(1'b0, `ACS_DEV_ADDR, k);
    `ACS_CHK(k, 1'b1)
    u_acs_i2c_master.byte_x(b, r);
    u_acs_i2c_master.bit_x(1'b1, k);
    `ACS_CHK(k, 1'b0)
    u_acs_i2c_master.stop();
  endtask : wr
  // read address; conversions start here
  task automatic rd_go();
    logic k;
    waddr(1'b1, `ACS_DEV_ADDR, k);
    `ACS_CHK(k, 1'b1)
    kb = kc;
  endtask : rd_go
  // one two-byte result, nack on the last
  task automatic rres(input logic [11:0] e, input logic last);
    logic [7:0] h, l;
    logic n;
    u_acs_i2c_master.byte_x(8'hFF, h);
    u_acs_i2c_master.bit_x(1'b0, n);
    `ACS_CHK(h, {4'hF, e[11:8]})
    u_acs_i2c_master.byte_x(8'hFF, l);
    u_acs_i2c_master.bit_x(last, n);
    `ACS_CHK(l, e[7:0])
  endtask : rres
  task automatic rd_end();
    `ACS_CHK(sda_oe, 1'b0)
    u_acs_i2c_master.stop();
  endtask : rd_end
  initial begin
    repeat (12) @(posedge ref_clk);
    #1;
    `ACS_CHK({refs, gnd, ext, scl_oe, sda_oe}, 9'h108)
    @(negedge ref_clk) rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    waddr(1'b1, `ACS_DEV_ADDR ^ 7'h01, ack);
    `ACS_CHK(ack, 1'b0)
    u_acs_i2c_master.stop();
    foreach (rows[i]) begin
      wr(rows[i][12:5]);
      `ACS_CHK(refs, rows[i][4:0])
    end
    // scan up to input one, then read past the end
    wr(8'h03);
    rd_go();
    rres(12'h5A0 + kb, 1'b0);
    rres(12'h5A0 + kb + 12'h001, 1'b0);
    rres(12'h5A0 + kb, 1'b1);
    rd_end();
    // eight runs, last two kept
    wr(8'h23);
    rd_go();
    rres(12'h5A0 + kb + 12'h006, 1'b0);
    rres(12'h5A0 + kb + 12'h007, 1'b1);
    `ACS_CHK(kc - kb, 12'h008)
    rd_end();
    // differential, reversed pair, single conversion
    wr(8'h62);
    rd_go();
    rres(12'h5A0 + kb, 1'b1);
    `ACS_CHK({pos, neg, gnd}, 3'b100)
    rd_end();
    // setup with restore bit low brings back defaults
    wr(8'h80);
    rd_go();
    rres(12'h5A0 + kb, 1'b1);
    `ACS_CHK({gnd, pos, kc - kb}, 14'h2001)
    rd_end();
    // external clock, bipolar: results stream until nack
    wr(8'h8E);
    wr(8'h03);
    `ACS_CHK({ext, pol}, 2'h3)
    rd_go();
    rres(12'h5A0 + kb, 1'b0);
    rres(12'h5A0 + kb + 12'h001, 1'b0);
    rres(12'h5A0 + kb + 12'h002, 1'b1);
    `ACS_CHK(kc - kb, 12'h003)
    rd_end();
    // reset after the last stop brings back the power-up setup
    @(negedge ref_clk) rst = 1'b1;
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    `ACS_CHK({refs, gnd, ext, pol, scl_oe}, 9'h108)
    final_report();
  end
endmodule : acs_seq_bench
